// ---- uhlp_pkg.sv ----
// constants for the host list pointer register bank
package uhlp_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 8;
    // register byte offsets
    localparam logic [7:0]  OFS_PERIODIC    = 8'h1C;
    localparam logic [7:0]  OFS_CTRL_HEAD   = 8'h20;
    localparam logic [7:0]  OFS_CTRL_CUR    = 8'h24;
    // pointer field sits in bits 31..4, bits 3..0 are reserved
    localparam int          PTR_LSB         = 4;
    localparam logic [31:0] PTR_MASK        = 32'hFFFFFFF0;
    localparam logic [31:0] PTR_RESET       = 32'h00000000;
    localparam logic [31:0] END_OF_LIST     = 32'h00000000;
    // list flag in command status, list enable in control
    localparam int          FILLED_BIT      = 1;
    localparam int          LIST_ENABLE_BIT = 4;
    localparam logic        FLAG_RESET      = 1'b0;
    localparam logic [31:0] RDATA_RESET     = 32'h00000000;
    localparam logic [31:0] UNMAPPED_RDATA  = 32'h00000000;
endpackage

// ---- uhlp_ptr_reg.sv ----
// one aligned descriptor pointer with a single load port
`timescale 1ns/1ns
`default_nettype none
module uhlp_ptr_reg
    import uhlp_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire logic                        load,
    input  wire logic [uhlp_pkg::DATA_W-1:0] load_addr,
    output logic      [uhlp_pkg::DATA_W-1:0] addr
);
    logic [DATA_W-1:0] next_addr;

    // low address bits never store, so reads show them as zero
    always_comb
    begin
        next_addr = addr;
        if (load)
        begin
            next_addr = load_addr & PTR_MASK; // RULE17
        end
    end

    // register with synchronous reset to zero
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            addr <= PTR_RESET;
        end
        else
        begin
            addr <= next_addr;
        end
    end
endmodule
`default_nettype wire

// ---- uhlp_flag.sv ----
// sticky flag where a set in the same cycle beats a clear
`timescale 1ns/1ns
`default_nettype none
module uhlp_flag
    import uhlp_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic set,
    input  wire logic clear,
    output logic      flag
);
    logic next_flag;

    // set wins over clear so no fill notice is lost
    always_comb
    begin
        next_flag = flag;
        if (clear)
        begin
            next_flag = 1'b0;
        end
        if (set)
        begin
            next_flag = 1'b1;
        end
    end

    // flag register
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            flag <= FLAG_RESET;
        end
        else
        begin
            flag <= next_flag;
        end
    end
endmodule
`default_nettype wire

// ---- uhlp_list_ptrs.sv ----
// periodic and control list pointer registers of the host list engine
//
// Operation
// RULE1 - periodic current pointer lives at 1Ch
// RULE2 - periodic pointer bits 31..4 name frame list
// RULE3 - engine updates periodic pointer per descriptor
// RULE4 - reads return live periodic pointer value
// RULE5 - control head pointer lives at 20h
// RULE6 - control traversal starts from head pointer
// RULE7 - head pointer loaded from comm area
// RULE8 - control current pointer lives at 24h
// RULE9 - current pointer advances after serving descriptor
// RULE10 - new frame resumes where control stopped
// RULE11 - end of list tests filled flag
// RULE12 - flag set: copy head, clear flag
// RULE13 - flag clear: change nothing at end
// RULE14 - software writes current only when disabled
// RULE15 - while enabled software only reads current
// RULE16 - current pointer resets to zero
// RULE17 - low four pointer bits read zero
`timescale 1ns/1ns
`default_nettype none
module uhlp_list_ptrs
    import uhlp_pkg::*;
(
    input  wire logic                        MCLK,
    input  wire logic                        RESETN,
    // register access
    input  wire logic [uhlp_pkg::ADDR_W-1:0] REG_ADDR,
    input  wire logic                        REG_READ,
    input  wire logic                        REG_WRITE,
    input  wire logic [uhlp_pkg::DATA_W-1:0] REG_WDATA,
    output logic      [uhlp_pkg::DATA_W-1:0] REG_RDATA,
    output logic                             REG_RVALID,
    // command status write and control register value
    input  wire logic                        CMD_STATUS_WRITE,
    input  wire logic [uhlp_pkg::DATA_W-1:0] CMD_STATUS_WDATA,
    input  wire logic [uhlp_pkg::DATA_W-1:0] CONTROL_REG,
    // initialization from the communication area
    input  wire logic                        COMM_AREA_LOAD,
    input  wire logic [uhlp_pkg::DATA_W-1:0] COMM_AREA_HEAD_ADDR,
    // periodic list engine
    input  wire logic                        PERIODIC_START,
    input  wire logic [uhlp_pkg::DATA_W-1:0] PERIODIC_HEAD,
    input  wire logic                        PERIODIC_DONE,
    input  wire logic [uhlp_pkg::DATA_W-1:0] PERIODIC_NEXT,
    // control list engine
    input  wire logic                        FRAME_START,
    input  wire logic                        CTRL_DONE,
    input  wire logic [uhlp_pkg::DATA_W-1:0] CTRL_NEXT,
    input  wire logic                        CTRL_END,
    // pointer and flag state toward the engine
    output logic      [uhlp_pkg::DATA_W-1:0] PERIODIC_CURRENT_ADDR,
    output logic      [uhlp_pkg::DATA_W-1:0] CONTROL_HEAD_ADDR,
    output logic      [uhlp_pkg::DATA_W-1:0] CONTROL_CURRENT_ADDR,
    output logic                             CONTROL_LIST_FILLED
);
    logic              control_list_enable;
    logic              sw_hit_cur;
    logic              filled_set;
    logic              list_end;
    logic              wrap_to_head;
    logic              periodic_load;
    logic [DATA_W-1:0] periodic_load_addr;
    logic              cur_load;
    logic [DATA_W-1:0] cur_load_addr;
    logic [DATA_W-1:0] next_rdata;
    logic              next_rvalid;

    // decode of one register offset
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign control_list_enable = CONTROL_REG[LIST_ENABLE_BIT];
    assign filled_set = CMD_STATUS_WRITE && CMD_STATUS_WDATA[FILLED_BIT];
    // software write to current pointer is taken only while the list is disabled
    assign sw_hit_cur = REG_WRITE && hit(REG_ADDR, OFS_CTRL_CUR) && !control_list_enable; // RULE15

    // end of list: explicit end, or an advance onto the null link
    assign list_end = CTRL_END || (CTRL_DONE && ((CTRL_NEXT & PTR_MASK) == END_OF_LIST)); // RULE11
    assign wrap_to_head = list_end && CONTROL_LIST_FILLED; // RULE12

    // periodic pointer: frame head first, then per-descriptor updates
    always_comb
    begin
        periodic_load = PERIODIC_START || PERIODIC_DONE;
        periodic_load_addr = PERIODIC_HEAD; // RULE2
        if (PERIODIC_DONE)
        begin
            periodic_load_addr = PERIODIC_NEXT; // RULE3
        end
    end

    // control current pointer: engine events take priority over software
    always_comb
    begin
        cur_load = 1'b0; // RULE10
        cur_load_addr = CONTROL_CURRENT_ADDR;
        if (wrap_to_head)
        begin
            cur_load = 1'b1;
            cur_load_addr = CONTROL_HEAD_ADDR; // RULE6
        end
        else if (CTRL_DONE)
        begin
            cur_load = 1'b1;
            cur_load_addr = CTRL_NEXT; // RULE9
        end
        else if (sw_hit_cur)
        begin
            cur_load = 1'b1;
            cur_load_addr = REG_WDATA; // RULE14
        end
        // frame start alone loads nothing, so work resumes in place
    end

    // periodic current pointer register
    uhlp_ptr_reg u_periodic ( // RULE1
        .mclk      (MCLK),
        .resetn    (RESETN),
        .load      (periodic_load),
        .load_addr (periodic_load_addr),
        .addr      (PERIODIC_CURRENT_ADDR)
    );

    // control head pointer, filled at initialization
    uhlp_ptr_reg u_ctrl_head ( // RULE5
        .mclk      (MCLK),
        .resetn    (RESETN),
        .load      (COMM_AREA_LOAD), // RULE7
        .load_addr (COMM_AREA_HEAD_ADDR),
        .addr      (CONTROL_HEAD_ADDR)
    );

    // control current pointer, zero after reset marks an empty list
    uhlp_ptr_reg u_ctrl_cur ( // RULE8
        .mclk      (MCLK),
        .resetn    (RESETN), // RULE16
        .load      (cur_load),
        .load_addr (cur_load_addr),
        .addr      (CONTROL_CURRENT_ADDR)
    );

    // filled flag cleared only by a wrap; with no wrap and no set it holds
    uhlp_flag u_filled (
        .mclk   (MCLK),
        .resetn (RESETN),
        .set    (filled_set),
        .clear  (wrap_to_head), // RULE13
        .flag   (CONTROL_LIST_FILLED)
    );

    // read mux; pointers are read live and unmapped offsets read zero
    always_comb
    begin
        next_rvalid = REG_READ;
        next_rdata = REG_RDATA;
        if (REG_READ)
        begin
            if (hit(REG_ADDR, OFS_PERIODIC))
            begin
                next_rdata = PERIODIC_CURRENT_ADDR; // RULE4
            end
            else if (hit(REG_ADDR, OFS_CTRL_HEAD))
            begin
                next_rdata = CONTROL_HEAD_ADDR;
            end
            else if (hit(REG_ADDR, OFS_CTRL_CUR))
            begin
                next_rdata = CONTROL_CURRENT_ADDR;
            end
            else
            begin
                next_rdata = UNMAPPED_RDATA;
            end
        end
    end

    // read data register
    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            REG_RDATA <= RDATA_RESET;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RDATA <= next_rdata;
            REG_RVALID <= next_rvalid;
        end
    end

    // checks on the pointer behaviour
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    a_periodic_read_live: assert property ( // RULE4
        REG_READ && REG_ADDR == OFS_PERIODIC |=> REG_RDATA == $past(PERIODIC_CURRENT_ADDR))
        else $error("periodic read not live");

    a_periodic_done_load: assert property ( // RULE3
        PERIODIC_DONE |=> PERIODIC_CURRENT_ADDR == $past(PERIODIC_NEXT & PTR_MASK))
        else $error("periodic pointer not updated");

    a_periodic_frame_head: assert property ( // RULE2
        PERIODIC_START && !PERIODIC_DONE
        |=> PERIODIC_CURRENT_ADDR == $past(PERIODIC_HEAD & PTR_MASK))
        else $error("periodic head not taken");

    a_low_bits_zero: assert property ( // RULE17
        (PERIODIC_CURRENT_ADDR[PTR_LSB-1:0] | CONTROL_HEAD_ADDR[PTR_LSB-1:0]
         | CONTROL_CURRENT_ADDR[PTR_LSB-1:0]) == 4'h0)
        else $error("pointer low bits not zero");

    a_head_init_load: assert property ( // RULE7
        COMM_AREA_LOAD |=> CONTROL_HEAD_ADDR == $past(COMM_AREA_HEAD_ADDR & PTR_MASK))
        else $error("head not loaded at init");

    a_ctrl_advance: assert property ( // RULE9
        CTRL_DONE && (CTRL_NEXT & PTR_MASK) != END_OF_LIST && !CTRL_END
        |=> CONTROL_CURRENT_ADDR == $past(CTRL_NEXT & PTR_MASK))
        else $error("control pointer did not advance");

    a_filled_wrap_head: assert property ( // RULE12
        list_end && CONTROL_LIST_FILLED && !filled_set
        |=> CONTROL_CURRENT_ADDR == $past(CONTROL_HEAD_ADDR) && !CONTROL_LIST_FILLED)
        else $error("wrap to head failed");

    a_filled_clear_hold: assert property ( // RULE13
        CTRL_END && !CTRL_DONE && !CONTROL_LIST_FILLED && !sw_hit_cur && !filled_set
        |=> $stable(CONTROL_CURRENT_ADDR) && !CONTROL_LIST_FILLED)
        else $error("end of list changed state");

    a_frame_resume: assert property ( // RULE10
        FRAME_START && !CTRL_DONE && !CTRL_END && !sw_hit_cur
        |=> $stable(CONTROL_CURRENT_ADDR))
        else $error("frame start moved control pointer");

    a_sw_write_blocked: assert property ( // RULE15
        REG_WRITE && REG_ADDR == OFS_CTRL_CUR && control_list_enable
        && !CTRL_DONE && !CTRL_END |=> $stable(CONTROL_CURRENT_ADDR))
        else $error("write taken while list enabled");

    a_filled_set_wins: assert property (
        filled_set |=> CONTROL_LIST_FILLED)
        else $error("flag set lost");

    a_reset_zero: assert property (@(posedge MCLK) disable iff (1'b0) // RULE16
        !RESETN |=> CONTROL_CURRENT_ADDR == PTR_RESET && !CONTROL_LIST_FILLED)
        else $error("current pointer not zero after reset");

    a_head_sw_ignored: assert property ( // RULE5
        REG_WRITE && REG_ADDR == OFS_CTRL_HEAD && !COMM_AREA_LOAD
        |=> $stable(CONTROL_HEAD_ADDR))
        else $error("head pointer took a software write");

    a_periodic_sw_ignored: assert property ( // RULE1
        REG_WRITE && REG_ADDR == OFS_PERIODIC && !PERIODIC_START && !PERIODIC_DONE
        |=> $stable(PERIODIC_CURRENT_ADDR))
        else $error("periodic pointer took a software write");

    a_sw_write_taken: assert property ( // RULE14
        sw_hit_cur && !CTRL_DONE && !list_end
        |=> CONTROL_CURRENT_ADDR == $past(REG_WDATA & PTR_MASK))
        else $error("current pointer write lost");

    a_null_link_stop: assert property ( // RULE13
        CTRL_DONE && (CTRL_NEXT & PTR_MASK) == END_OF_LIST && !CONTROL_LIST_FILLED
        |=> CONTROL_CURRENT_ADDR == END_OF_LIST)
        else $error("null link not stored");

    a_read_valid: assert property (
        $past(RESETN) |-> REG_RVALID == $past(REG_READ))
        else $error("read valid not one cycle after read");

    a_unmapped_zero: assert property (
        REG_READ && !hit(REG_ADDR, OFS_PERIODIC) && !hit(REG_ADDR, OFS_CTRL_HEAD)
        && !hit(REG_ADDR, OFS_CTRL_CUR) |=> REG_RDATA == UNMAPPED_RDATA)
        else $error("unmapped offset read not zero");

    a_current_read_live: assert property ( // RULE8
        REG_READ && REG_ADDR == OFS_CTRL_CUR |=> REG_RDATA == $past(CONTROL_CURRENT_ADDR))
        else $error("current pointer read not live");

    a_head_read_live: assert property ( // RULE5
        REG_READ && REG_ADDR == OFS_CTRL_HEAD |=> REG_RDATA == $past(CONTROL_HEAD_ADDR))
        else $error("head pointer read not live");

    a_flag_hold: assert property ( // RULE13
        RESETN && !filled_set && !wrap_to_head |=> $stable(CONTROL_LIST_FILLED))
        else $error("filled flag changed with no cause");

    c_wrap_to_head: cover property (wrap_to_head);
    c_sw_write: cover property (sw_hit_cur ##1 CTRL_DONE);
    c_periodic_walk: cover property (PERIODIC_START ##[1:4] PERIODIC_DONE);
    c_end_no_flag: cover property (CTRL_END && !CONTROL_LIST_FILLED);
    c_set_and_wrap: cover property (wrap_to_head && filled_set);
endmodule
`default_nettype wire

// ---- uhlp_desc_mem.sv ----
// descriptor memory model: gives the link field of each control list descriptor
`timescale 1ns/1ns
`default_nettype none
module uhlp_desc_mem
    import uhlp_pkg::*;
(
    input  wire logic [uhlp_pkg::DATA_W-1:0] desc_addr,
    output logic      [uhlp_pkg::DATA_W-1:0] link_addr
);
    // three chained descriptors, the last one closes the list
    always_comb
    begin
        case (desc_addr)
            32'h00000100: link_addr = 32'h00000140;
            32'h00000140: link_addr = 32'h00000180;
            32'h00000180: link_addr = END_OF_LIST;
            default:      link_addr = ~desc_addr; // no descriptor here, junk
        endcase
    end
endmodule
`default_nettype wire

// ---- test_usb_host_list_pointers.sv ----
// self-checking bench for the list pointer register bank
`timescale 1ns/1ns
`default_nettype none
module test_usb_host_list_pointers;
    import uhlp_pkg::*;
    logic        mclk, resetn, rd, wr, cs_wr, area_ld, p_start, p_done, frame, c_done, c_end;
    logic        rvalid, filled;
    logic [7:0]  addr;
    logic [31:0] wdata, cs_wdata, ctrl_reg, area_head, p_head, p_next, c_next, link;
    logic [31:0] rdata, pcur, chead, ccur;
    int          miscompares = 0;
    int          num_checks = 0;

    uhlp_list_ptrs dut (.MCLK(mclk), .RESETN(resetn), .REG_ADDR(addr), .REG_READ(rd),
        .REG_WRITE(wr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .CMD_STATUS_WRITE(cs_wr), .CMD_STATUS_WDATA(cs_wdata), .CONTROL_REG(ctrl_reg),
        .COMM_AREA_LOAD(area_ld), .COMM_AREA_HEAD_ADDR(area_head), .PERIODIC_START(p_start),
        .PERIODIC_HEAD(p_head), .PERIODIC_DONE(p_done), .PERIODIC_NEXT(p_next),
        .FRAME_START(frame), .CTRL_DONE(c_done), .CTRL_NEXT(c_next), .CTRL_END(c_end),
        .PERIODIC_CURRENT_ADDR(pcur), .CONTROL_HEAD_ADDR(chead),
        .CONTROL_CURRENT_ADDR(ccur), .CONTROL_LIST_FILLED(filled));

    uhlp_desc_mem mem (.desc_addr(ccur), .link_addr(link));

    // 50 MHz clock
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    task automatic report_and_stop();
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // wait the sampling edge, drop every strobe, let outputs settle
    task automatic tick();
        @(posedge mclk);
        {rd, wr, cs_wr, area_ld, p_start, p_done, frame, c_done, c_end} <= '0;
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        tick();
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        tick();
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk(name, exp, rdata);
    endtask

    // one engine event on the control list, link taken from the memory model
    task automatic ctrl_step(input logic done, input logic endl, input logic set_flag);
        @(posedge mclk);
        c_next <= link;
        c_done <= done;
        c_end  <= endl;
        cs_wr  <= set_flag;
        tick();
    endtask

    // reset values and unmapped offset
    task automatic t_reset();
        reg_rd(OFS_PERIODIC, PTR_RESET, "periodic");
        reg_rd(OFS_CTRL_HEAD, PTR_RESET, "head");
        reg_rd(OFS_CTRL_CUR, END_OF_LIST, "current");
        reg_rd(8'h28, UNMAPPED_RDATA, "unmapped");
        chk("filled", 32'h0, {31'h0, filled});
    endtask

    // head load from comm area, read-only registers ignore writes
    task automatic t_init();
        @(posedge mclk);
        area_head <= 32'h0000010F;
        area_ld   <= 1'b1;
        tick();
        chk("head", 32'h0000010F & PTR_MASK, chead);
        reg_wr(OFS_CTRL_HEAD, 32'h00000500);
        reg_rd(OFS_CTRL_HEAD, 32'h00000100, "head reg");
        reg_wr(OFS_PERIODIC, 32'h00000500);
        reg_rd(OFS_PERIODIC, PTR_RESET, "periodic reg");
    endtask

    // periodic pointer loads frame head, then advances, done beats start
    task automatic t_periodic();
        @(posedge mclk);
        p_head  <= 32'h00002009;
        p_start <= 1'b1;
        tick();
        reg_rd(OFS_PERIODIC, 32'h00002000, "periodic head");
        @(posedge mclk);
        p_next  <= 32'h00003004;
        p_done  <= 1'b1;
        p_start <= 1'b1;
        tick();
        chk("periodic next", 32'h00003000, pcur);
        reg_rd(OFS_PERIODIC, 32'h00003000, "periodic live");
    endtask

    // software write gated by list enable, walk to end with flag clear
    task automatic t_walk();
        logic [31:0] chain [3] = '{32'h140, 32'h180, END_OF_LIST};
        reg_wr(OFS_CTRL_CUR, 32'h0000010C);
        reg_rd(OFS_CTRL_CUR, 32'h00000100, "current wr");
        @(posedge mclk);
        ctrl_reg <= 32'h1 << LIST_ENABLE_BIT;
        reg_wr(OFS_CTRL_CUR, 32'h00000500);
        reg_rd(OFS_CTRL_CUR, 32'h00000100, "current locked");
        for (int i = 0; i < 3; i++)
        begin
            ctrl_step(1'b1, 1'b0, 1'b0);
            chk("advance", chain[i], ccur);
            @(posedge mclk);
            frame <= 1'b1;
            tick();
            chk("frame keep", chain[i], ccur);
        end
        ctrl_step(1'b0, 1'b1, 1'b0);
        chk("end no flag", END_OF_LIST, ccur);
        chk("flag clear", 32'h0, {31'h0, filled});
    endtask

    // wrap to head when flag set, by end and by null link, set beats clear
    task automatic t_wrap();
        @(posedge mclk);
        cs_wdata <= ~(32'h1 << FILLED_BIT);
        ctrl_step(1'b0, 1'b0, 1'b1);
        chk("flag other bits", 32'h0, {31'h0, filled});
        @(posedge mclk);
        cs_wdata <= 32'h1 << FILLED_BIT;
        ctrl_step(1'b0, 1'b0, 1'b1);
        chk("flag set", 32'h1, {31'h0, filled});
        ctrl_step(1'b0, 1'b1, 1'b0);
        chk("wrap end", 32'h00000100, ccur);
        chk("flag cleared", 32'h0, {31'h0, filled});
        ctrl_step(1'b1, 1'b0, 1'b0);
        ctrl_step(1'b1, 1'b0, 1'b1);
        ctrl_step(1'b1, 1'b0, 1'b0);
        chk("wrap null", 32'h00000100, ccur);
        ctrl_step(1'b0, 1'b1, 1'b1);
        chk("end no wrap", 32'h00000100, ccur);
        ctrl_step(1'b1, 1'b0, 1'b0);
        ctrl_step(1'b0, 1'b1, 1'b1);
        chk("set wins", 32'h1, {31'h0, filled});
        chk("wrap and set", 32'h00000100, ccur);
        @(posedge mclk);
        resetn <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b1;
        #1;
        chk("rereset", END_OF_LIST, ccur);
        chk("rereset flag", 32'h0, {31'h0, filled});
        chk("rereset head", PTR_RESET, chead);
    endtask

    // stimulus
    initial
    begin
        {rd, wr, cs_wr, area_ld, p_start, p_done, frame, c_done, c_end} = '0;
        {addr, wdata, ctrl_reg, area_head, p_head, p_next, c_next} = '0;
        cs_wdata = 32'h1 << FILLED_BIT;
        resetn = 1'b0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_init();
        t_periodic();
        t_walk();
        t_wrap();
        report_and_stop();
    end

    // watchdog
    initial
    begin
        repeat (1000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
